/* File: rtl/tws_pkg.sv */
/*
 * Constants shared by the two-wire slave port: register offsets, field
 * positions, reset values and phase codes.
 * Assumes an 8-bit register port with byte-wide offsets.
 */
package tws_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] FUNC_SEL_OFS  = 8'h9c;
   localparam logic [7:0] CONTROL_OFS   = 8'h9d;
   localparam logic [7:0] OWN_ADDR_OFS  = 8'h9e;
   localparam logic [7:0] DATA_BUF_OFS  = 8'h9f;

   ////////////////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int PORT_ENABLE_BIT = 7;
   localparam int EVENT_FLAG_BIT  = 6;
   localparam int GENERAL_CALL_HIT_BIT    = 4;
   localparam int ACK_ENABLE_BIT  = 3;
   localparam int PHASE_LSB       = 0;

   // Own address register fields
   localparam int ADDR_LSB        = 1;
   localparam int GENERAL_CALL_ENABLE_BIT = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [1:0] FUNC_SEL_RST  = 2'h0;
   localparam logic [7:0] OWN_ADDR_RST  = 8'h00;
   localparam logic [7:0] DATA_BUF_RST  = 8'h00;

   // Function select code of the two-wire port
   localparam logic [1:0] FUNC_TWO_WIRE = 2'h2;

   // General-call address
   localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Bit counter landmarks within one nine-clock byte
   localparam logic [3:0] CNT_DATA_DONE = 4'h8;
   localparam logic [3:0] CNT_ACK_DONE  = 4'h9;

   ////////////////////////////////////////////////////////////////////////////
   // Phase field codes
   localparam logic [2:0] PH_IDLE       = 3'h0;
   localparam logic [2:0] PH_ADDR       = 3'h1;
   localparam logic [2:0] PH_RX         = 3'h2;
   localparam logic [2:0] PH_TX         = 3'h3;
   localparam logic [2:0] PH_TX_NACK    = 3'h4;
   localparam logic [2:0] PH_TX_ABORT   = 3'h5;

   // Phase machine states
   typedef enum logic [2:0] {
      TWS_IDLE,
      TWS_ADDR,
      TWS_RX,
      TWS_TX,
      TWS_TX_NACK,
      TWS_TX_ABORT
   } tws_phase_t;

endpackage : tws_pkg

/* File: rtl/tws_line_if.sv */
/*
 * Synchronised line levels and line events passed from the line
 * synchroniser to the phase engine.
 * Assumes both ends run on core_clk.
 */
`timescale 1ns/100ps
`default_nettype none

interface tws_line_if;
   logic scl;        // Synchronised clock line level
   logic sda;        // Synchronised data line level
   logic scl_rise;   // One-cycle pulse on clock rise
   logic scl_fall;   // One-cycle pulse on clock fall
   logic start_det;  // One-cycle pulse on START
   logic stop_det;   // One-cycle pulse on STOP

   modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
   modport snk (input  scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface : tws_line_if

`default_nettype wire

/* File: rtl/tws_line_sync.sv */
/*
 * Two-flop synchronisers for the clock and data lines, followed by edge,
 * START and STOP detection.
 * Assumes the link clock is far slower than core_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module tws_line_sync (
   input  wire logic   core_clk,
   input  wire logic   rst,
   input  wire logic   scl_in,
   input  wire logic   sda_in,
   tws_line_if.src     line
);

   logic [1:0] scl_meta_r;
   logic [1:0] sda_meta_r;
   logic       scl_prev_r;
   logic       sda_prev_r;

   ////////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers, first stage read only by the second
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         scl_meta_r <= 2'h3;
         sda_meta_r <= 2'h3;
      end
      else
      begin
         scl_meta_r <= {scl_meta_r[0], scl_in};
         sda_meta_r <= {sda_meta_r[0], sda_in};
      end
   end

   // Previous synchronised levels for edge finding
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         scl_prev_r <= 1'b1;
         sda_prev_r <= 1'b1;
      end
      else
      begin
         scl_prev_r <= scl_meta_r[1];
         sda_prev_r <= sda_meta_r[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line events; START and STOP are data edges with the clock held high
   assign line.scl       = scl_meta_r[1];
   assign line.sda       = sda_meta_r[1];
   assign line.scl_rise  = scl_meta_r[1] & ~scl_prev_r;
   assign line.scl_fall  = ~scl_meta_r[1] & scl_prev_r;
   assign line.start_det = scl_meta_r[1] & scl_prev_r & sda_prev_r & ~sda_meta_r[1];
   assign line.stop_det  = scl_meta_r[1] & scl_prev_r & ~sda_prev_r & sda_meta_r[1];

endmodule : tws_line_sync

`default_nettype wire

/* File: rtl/tws_slave.sv */
/*
 * Slave-only two-wire serial port: register port, address decode, phase
 * machine, byte shifting and acknowledge handling.
 * Assumes an external pull-up on the data line and a master that owns the
 * clock line; the register port is driven from core_clk.
 */
// The register offsets and the plain strobed port are this design's own decisions.
// Notes on behaviour
// - Byte is eight data clocks plus acknowledge
// - Data line only pulled low or released
// - Slave only, never drives clock line
// - Enabled START moves idle to address phase
// - Own address match pulls acknowledge low
// - Write direction enters receive, acknowledges bytes
// - Receive continues; restart to address, STOP idle
// - Ack enable cleared: no acknowledge, go idle
// - Read direction drives bytes, releases for ack
// - Master low acknowledge sends next byte
// - Ack enable cleared in transmit: phase 101
// - Master high acknowledge: phase 100
// - General call with enable acknowledged, receive
// - No acknowledge leaves data line released
// - Event flag per received byte, software clears
// - Transmit buffer byte, event flag per byte
// - Phase reads 011 while transmitting
// - Event flag on match, restart, STOP
`timescale 1ns/100ps
`default_nettype none

module tws_slave (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe
);

   tws_line_if line ();

   logic [1:0]              func_sel_r;
   logic                    port_enable_r;
   logic                    event_flag_r;
   logic                    general_call_hit_r;
   logic                    ack_enable_r;
   logic [6:0]              own_addr_r;
   logic                    general_call_enable_r;
   logic [7:0]              data_buf_r;
   tws_pkg::tws_phase_t     phase_r;
   tws_pkg::tws_phase_t     phase_nxt;
   logic [3:0]              bit_cnt_r;
   logic [7:0]              shift_in_r;
   logic [7:0]              shift_out_r;
   logic                    drive_low_r;
   logic                    master_nack_r;
   logic [7:0]              reg_rdata_r;
   logic                    active;
   logic                    ack_point;
   logic                    byte_end;
   logic                    addr_hit;
   logic                    general_call_match;
   logic                    evt_set;
   logic                    wr_ctrl;
   logic                    rx_done;

   ////////////////////////////////////////////////////////////////////////////
   // Phase code of a machine state
   function automatic logic [2:0] phase_code(input tws_pkg::tws_phase_t ph);
      case (ph)
         tws_pkg::TWS_IDLE:     phase_code = tws_pkg::PH_IDLE;
         tws_pkg::TWS_ADDR:     phase_code = tws_pkg::PH_ADDR;
         tws_pkg::TWS_RX:       phase_code = tws_pkg::PH_RX;
         tws_pkg::TWS_TX:       phase_code = tws_pkg::PH_TX;
         tws_pkg::TWS_TX_NACK:  phase_code = tws_pkg::PH_TX_NACK;
         tws_pkg::TWS_TX_ABORT: phase_code = tws_pkg::PH_TX_ABORT;
         default:               phase_code = tws_pkg::PH_IDLE;
      endcase
   endfunction : phase_code

   // True for states in which the port has been addressed
   function automatic logic is_selected(input tws_pkg::tws_phase_t ph);
      is_selected = (ph != tws_pkg::TWS_IDLE) && (ph != tws_pkg::TWS_ADDR);
   endfunction : is_selected

   ////////////////////////////////////////////////////////////////////////////
   // Line synchroniser and event detector
   tws_line_sync u_line_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .line     (line.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decodes of the byte position and the first frame
   assign active    = port_enable_r && (func_sel_r == tws_pkg::FUNC_TWO_WIRE);
   assign ack_point = line.scl_fall && (bit_cnt_r == tws_pkg::CNT_DATA_DONE);
   assign byte_end  = line.scl_fall && (bit_cnt_r == tws_pkg::CNT_ACK_DONE);
   assign addr_hit  = (shift_in_r[7:1] == own_addr_r);
   assign general_call_match = general_call_enable_r
                      && (shift_in_r[7:1] == tws_pkg::GENERAL_CALL_ADDR)
                      && !shift_in_r[0];
   assign rx_done   = ack_point && (phase_r == tws_pkg::TWS_RX);
   assign wr_ctrl   = reg_wr && (reg_addr == tws_pkg::CONTROL_OFS);

   // Hardware events that raise the byte event flag
   always_comb
   begin
      evt_set = 1'b0;
      if (active)
      begin
         if (line.start_det && phase_r != tws_pkg::TWS_IDLE)
            evt_set = 1'b1;
         else if (line.stop_det && is_selected(phase_r))
            evt_set = 1'b1;
         else if (ack_point && phase_r == tws_pkg::TWS_ADDR && (addr_hit || general_call_match))
            evt_set = 1'b1;
         else if (ack_point && (phase_r == tws_pkg::TWS_RX || phase_r == tws_pkg::TWS_TX))
            evt_set = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Phase machine next state
   always_comb
   begin
      phase_nxt = phase_r;
      if (!active)
         phase_nxt = tws_pkg::TWS_IDLE;
      else if (line.start_det)
         phase_nxt = tws_pkg::TWS_ADDR;
      else if (line.stop_det)
         phase_nxt = tws_pkg::TWS_IDLE;
      else if (ack_point)
      begin
         case (phase_r)
            tws_pkg::TWS_ADDR:
            begin
               if (general_call_match)
                  phase_nxt = tws_pkg::TWS_RX;
               else if (addr_hit && shift_in_r[0])
                  phase_nxt = tws_pkg::TWS_TX;
               else if (addr_hit)
                  phase_nxt = tws_pkg::TWS_RX;
               else
                  phase_nxt = tws_pkg::TWS_IDLE;
            end
            tws_pkg::TWS_RX:
            begin
               if (!ack_enable_r)
                  phase_nxt = tws_pkg::TWS_IDLE;
            end
            tws_pkg::TWS_TX:
            begin
               if (!ack_enable_r)
                  phase_nxt = tws_pkg::TWS_TX_ABORT;
            end
            default:
               phase_nxt = phase_r;
         endcase
      end
      else if (byte_end && phase_r == tws_pkg::TWS_TX && master_nack_r)
         phase_nxt = tws_pkg::TWS_TX_NACK;
   end

   // Phase register
   always_ff @(posedge core_clk)
   begin
      if (rst)
         phase_r <= tws_pkg::TWS_IDLE;
      else
         phase_r <= phase_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bit counter across nine clocks per byte
   always_ff @(posedge core_clk)
   begin
      if (rst)
         bit_cnt_r <= 4'h0;
      else if (!active || line.start_det || line.stop_det)
         bit_cnt_r <= 4'h0;
      else if (byte_end)
         bit_cnt_r <= 4'h0;
      else if (line.scl_rise && bit_cnt_r <= tws_pkg::CNT_DATA_DONE)
         bit_cnt_r <= bit_cnt_r + 4'h1;
   end

   // Receive shifter, sampled on clock rise of the data bits
   always_ff @(posedge core_clk)
   begin
      if (rst)
         shift_in_r <= 8'h00;
      else if (line.scl_rise && bit_cnt_r < tws_pkg::CNT_DATA_DONE)
         shift_in_r <= {shift_in_r[6:0], line.sda};
   end

   // Master acknowledge sampled on the ninth clock rise
   always_ff @(posedge core_clk)
   begin
      if (rst)
         master_nack_r <= 1'b0;
      else if (line.scl_rise && bit_cnt_r == tws_pkg::CNT_DATA_DONE)
         master_nack_r <= line.sda;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit shifter, loaded from the data buffer at each byte start
   always_ff @(posedge core_clk)
   begin
      if (rst)
         shift_out_r <= 8'h00;
      else if (byte_end && phase_r == tws_pkg::TWS_TX && !master_nack_r)
         shift_out_r <= data_buf_r;
      else if (line.scl_fall && phase_r == tws_pkg::TWS_TX
               && bit_cnt_r != 4'h0 && bit_cnt_r < tws_pkg::CNT_DATA_DONE)
         shift_out_r <= {shift_out_r[6:0], 1'b0};
   end

   // Data line pull-down; the line is never driven high
   always_ff @(posedge core_clk)
   begin
      if (rst)
         drive_low_r <= 1'b0;
      else if (!active || line.start_det || line.stop_det)
         drive_low_r <= 1'b0;
      else if (ack_point)
      begin
         case (phase_r)
            tws_pkg::TWS_ADDR: drive_low_r <= addr_hit || general_call_match;
            tws_pkg::TWS_RX:   drive_low_r <= ack_enable_r;
            default:           drive_low_r <= 1'b0;
         endcase
      end
      else if (byte_end)
      begin
         if (phase_r == tws_pkg::TWS_TX && !master_nack_r)
            drive_low_r <= !data_buf_r[7];
         else
            drive_low_r <= 1'b0;
      end
      else if (line.scl_fall && phase_r == tws_pkg::TWS_TX
               && bit_cnt_r != 4'h0 && bit_cnt_r < tws_pkg::CNT_DATA_DONE)
         drive_low_r <= !shift_out_r[6];
   end

   // Open-drain pin: output held low, enable pulls the line
   assign sda_out = 1'b0;
   assign sda_oe  = drive_low_r;

   ////////////////////////////////////////////////////////////////////////////
   // Function select and own address registers
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         func_sel_r            <= tws_pkg::FUNC_SEL_RST;
         own_addr_r            <= tws_pkg::OWN_ADDR_RST[7:1];
         general_call_enable_r <= tws_pkg::OWN_ADDR_RST[tws_pkg::GENERAL_CALL_ENABLE_BIT];
      end
      else if (reg_wr)
      begin
         if (reg_addr == tws_pkg::FUNC_SEL_OFS)
            func_sel_r <= reg_wdata[1:0];
         if (reg_addr == tws_pkg::OWN_ADDR_OFS)
         begin
            own_addr_r            <= reg_wdata[7:1];
            general_call_enable_r <= reg_wdata[tws_pkg::GENERAL_CALL_ENABLE_BIT];
         end
      end
   end

   // Control register bits written by software
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         port_enable_r <= 1'b0;
         ack_enable_r  <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         port_enable_r <= reg_wdata[tws_pkg::PORT_ENABLE_BIT];
         ack_enable_r  <= reg_wdata[tws_pkg::ACK_ENABLE_BIT];
      end
   end

   // Byte event flag: hardware set beats software clear
   always_ff @(posedge core_clk)
   begin
      if (rst)
         event_flag_r <= 1'b0;
      else if (evt_set)
         event_flag_r <= 1'b1;
      else if (wr_ctrl && !reg_wdata[tws_pkg::EVENT_FLAG_BIT])
         event_flag_r <= 1'b0;
   end

   // General-call hit flag, cleared by the next START or STOP
   always_ff @(posedge core_clk)
   begin
      if (rst)
         general_call_hit_r <= 1'b0;
      else if (ack_point && phase_r == tws_pkg::TWS_ADDR && general_call_match && active)
         general_call_hit_r <= 1'b1;
      else if (line.start_det || line.stop_det || !active)
         general_call_hit_r <= 1'b0;
   end

   // Data buffer: received byte lands in the same cycle as the flag rises
   always_ff @(posedge core_clk)
   begin
      if (rst)
         data_buf_r <= tws_pkg::DATA_BUF_RST;
      else if (rx_done && active)
         data_buf_r <= shift_in_r;
      else if (reg_wr && reg_addr == tws_pkg::DATA_BUF_OFS)
         data_buf_r <= reg_wdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, valid only in the cycle after the read strobe
   always_ff @(posedge core_clk)
   begin
      if (rst)
         reg_rdata_r <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            tws_pkg::FUNC_SEL_OFS: reg_rdata_r <= {6'h00, func_sel_r};
            tws_pkg::CONTROL_OFS:  reg_rdata_r <= {port_enable_r, event_flag_r, 1'b0,
                                                   general_call_hit_r, ack_enable_r,
                                                   phase_code(phase_r)};
            tws_pkg::OWN_ADDR_OFS: reg_rdata_r <= {own_addr_r, general_call_enable_r};
            tws_pkg::DATA_BUF_OFS: reg_rdata_r <= data_buf_r;
            default:               reg_rdata_r <= 8'h00;
         endcase
      end
      else
         reg_rdata_r <= 8'h00;
   end

   assign reg_rdata = reg_rdata_r;

endmodule : tws_slave

`default_nettype wire

/* File: bench/tws_slave_asserts.sv */
/* Port checker for tws_slave, bound to every instance.
   Assumes one core_clk domain and the synchronous rst of the design. */
`timescale 1ns/100ps
`default_nettype none

module tws_slave_asserts (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////
   // Data line: pulled low or released only
   low_only_a : assert property (sda_out == 1'b0)
      else $error("sda_out not held low");
   // Released and quiet right after reset
   reset_quiet_a : assert property ($past(rst) |-> !sda_oe && reg_rdata == 8'h00)
      else $error("outputs busy after reset");
   // No change while the clock line stays high
   oe_clock_high_a : assert property (scl_in [*6] |-> $stable(sda_oe))
      else $error("sda_oe moved with clock high");
   // Changes only in the clock low half
   oe_clock_low_a : assert property ($changed(sda_oe) |-> !scl_in)
      else $error("sda_oe moved outside clock low");
   // A pulled bit stands for at least nine core_clk cycles
   oe_hold_a : assert property ($rose(sda_oe) |=> sda_oe [*8])
      else $error("sda_oe pulse too short");

   ////////////////////////////////////////////////////////////////////////////
   // Read data only in the cycle after a read
   rdata_idle_a : assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("reg_rdata not zero");
   // Unused control bit reads zero
   reserved_zero_a : assert property (reg_rd && reg_addr == tws_pkg::CONTROL_OFS
      |=> reg_rdata[5] == 1'b0)
      else $error("reserved control bit set");
   // Own address reads back what was written
   own_readback_a : assert property (reg_wr && reg_addr == tws_pkg::OWN_ADDR_OFS
      ##1 !reg_wr ##1 reg_rd && reg_addr == tws_pkg::OWN_ADDR_OFS
      |=> reg_rdata == $past(reg_wdata, 3))
      else $error("own address readback wrong");
endmodule : tws_slave_asserts

bind tws_slave tws_slave_asserts i_tws_slave_asserts (
   .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
);

`default_nettype wire

/* File: bench/tws_master_model.sv */
/* Behavioural two-wire bus master, 160 ns link period.
   Assumes a pull-up: the wire is high unless a party pulls it. */
`timescale 1ns/100ps
`default_nettype none

module tws_master_model (
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   localparam int Q = 40; // Quarter link period

   // Clock line rests high outside frames
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // START or repeated START, clock left low
   task start;
      #1; // Keep line changes off core clock edges
      sda_pull = 1'b0;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b1;
      #Q scl = 1'b0;
      #Q;
   endtask : start

   // STOP, clock left high
   task stop;
      #1; // Keep line changes off core clock edges
      sda_pull = 1'b1;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b0;
      #Q;
   endtask : stop

   // One clock: present a bit, sample with clock high
   task bitx(input logic b, output logic r);
      sda_pull = ~b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q scl = 1'b0;
      #Q;
   endtask : bitx

   // Eight data clocks MSB first, then the acknowledge clock
   task xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
      #1; // Keep line changes off core clock edges
      for (int i = 7; i >= 0; i--)
         bitx(d[i], q[i]);
      bitx(ai, ao);
      sda_pull = 1'b0;
   endtask : xfer
endmodule : tws_master_model

`default_nettype wire

/* File: bench/testbench.sv */
/* Self-checking bench for tws_slave against a behavioural bus master.
   Assumes the port checker is bound from its own file. */
`timescale 1ns/100ps
`default_nettype none

module testbench;
   logic        core_clk;
   logic        rst;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic        sda_out;
   logic        sda_oe;
   logic        scl;
   logic        m_pull;
   logic        sda;
   logic [31:0] seed;
   logic [6:0]  own;
   logic [7:0]  d;
   logic [7:0]  t;
   logic [7:0]  q;
   logic        ack;
   int          fails;
   int          tests_run;

   // Wired-AND line with pull-up
   assign sda = ~(sda_oe | m_pull);
   initial core_clk = 1'b0;
   always #2.5 core_clk = ~core_clk;

   tws_slave i_tws_slave (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
   tws_master_model i_tws_master_model (.scl(scl), .sda_pull(m_pull), .sda(sda));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Expected control value with the port enabled
   function automatic logic [7:0] ctl(input logic f, g, a, input logic [2:0] p);
      return {1'b1, f, 1'b0, g, a, p};
   endfunction : ctl
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   // Check control, then clear the event flag
   task ctl_chk(input logic [7:0] e);
      logic [7:0] v;
      rd(tws_pkg::CONTROL_OFS, v);
      chk("control", e, v);
      wr(tws_pkg::CONTROL_OFS, e & 8'h88);
   endtask : ctl_chk
   task bus(input logic [7:0] v, input logic ai);
      i_tws_master_model.xfer(v, ai, q, ack);
   endtask : bus
   task conclude;
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial
   begin
      #200000;
      fails++;
      conclude();
   end

   initial
   begin
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      fails = 0;
      tests_run = 0;
      seed = lfsr(32'h6b3a25cf);
      own = seed[6:0] | 7'h40;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      // Reset values, one unmapped offset
      for (int a = 8'h9b; a <= 8'h9f; a++)
      begin
         rd(a[7:0], d);
         chk("reset", 8'h00, d);
      end
      wr(tws_pkg::FUNC_SEL_OFS, {6'h00, tws_pkg::FUNC_TWO_WIRE});
      wr(tws_pkg::CONTROL_OFS, 8'h88);
      wr(tws_pkg::OWN_ADDR_OFS, {own, 1'b1});
      rd(tws_pkg::OWN_ADDR_OFS, d);
      chk("own address", {own, 1'b1}, d);
      // Write transfer with corner and random bytes
      i_tws_master_model.start();
      ctl_chk(ctl(1'b0, 1'b0, 1'b1, tws_pkg::PH_ADDR));
      bus({own, 1'b0}, 1'b1);
      chk("address ack", 8'h00, {7'h00, ack});
      ctl_chk(ctl(1'b1, 1'b0, 1'b1, tws_pkg::PH_RX));
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         t = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
         bus(t, 1'b1);
         chk("rx ack", 8'h00, {7'h00, ack});
         rd(tws_pkg::DATA_BUF_OFS, d);
         chk("rx data", t, d);
         ctl_chk(ctl(1'b1, 1'b0, 1'b1, tws_pkg::PH_RX));
      end
      // Repeated START, then read transfer
      i_tws_master_model.start();
      ctl_chk(ctl(1'b1, 1'b0, 1'b1, tws_pkg::PH_ADDR));
      wr(tws_pkg::DATA_BUF_OFS, seed[7:0]);
      bus({own, 1'b1}, 1'b1);
      chk("read ack", 8'h00, {7'h00, ack});
      ctl_chk(ctl(1'b1, 1'b0, 1'b1, tws_pkg::PH_TX));
      for (int i = 0; i < 2; i++)
      begin
         t = seed[7:0];
         seed = lfsr(seed);
         wr(tws_pkg::DATA_BUF_OFS, seed[7:0]);
         if (i == 1)
            wr(tws_pkg::CONTROL_OFS, 8'h80);
         bus(8'hff, 1'b0);
         chk("tx data", t, q);
         ctl_chk(ctl(1'b1, 1'b0, i == 0, i == 0 ? tws_pkg::PH_TX : tws_pkg::PH_TX_ABORT));
      end
      i_tws_master_model.stop();
      ctl_chk(ctl(1'b1, 1'b0, 1'b0, tws_pkg::PH_IDLE));
      // Master declines after one byte
      wr(tws_pkg::CONTROL_OFS, 8'h88);
      i_tws_master_model.start();
      bus({own, 1'b1}, 1'b1);
      ctl_chk(ctl(1'b1, 1'b0, 1'b1, tws_pkg::PH_TX));
      bus(8'hff, 1'b1);
      chk("tx data", seed[7:0], q);
      ctl_chk(ctl(1'b1, 1'b0, 1'b1, tws_pkg::PH_TX_NACK));
      i_tws_master_model.stop();
      // General call, then receive without acknowledge
      i_tws_master_model.start();
      bus(8'h00, 1'b1);
      chk("general ack", 8'h00, {7'h00, ack});
      ctl_chk(ctl(1'b1, 1'b1, 1'b1, tws_pkg::PH_RX));
      wr(tws_pkg::CONTROL_OFS, 8'h80);
      seed = lfsr(seed);
      bus(seed[15:8], 1'b1);
      chk("no ack", 8'h01, {7'h00, ack});
      ctl_chk(ctl(1'b1, 1'b1, 1'b0, tws_pkg::PH_IDLE));
      i_tws_master_model.stop();
      // Foreign address ignored
      wr(tws_pkg::CONTROL_OFS, 8'h88);
      i_tws_master_model.start();
      bus({own ^ 7'h01, 1'b0}, 1'b1);
      chk("foreign ack", 8'h01, {7'h00, ack});
      ctl_chk(ctl(1'b0, 1'b0, 1'b1, tws_pkg::PH_IDLE));
      i_tws_master_model.stop();
      // Disabled port ignores its own address
      wr(tws_pkg::CONTROL_OFS, 8'h08);
      i_tws_master_model.start();
      bus({own, 1'b0}, 1'b1);
      chk("disabled ack", 8'h01, {7'h00, ack});
      rd(tws_pkg::CONTROL_OFS, d);
      chk("disabled control", 8'h08, d);
      i_tws_master_model.stop();
      conclude();
   end
endmodule : testbench

`default_nettype wire
